// ==== src/etrc_top.sv ====
// Purpose: run control and real-time trace capture of an emulator
// Assumes: bus-cycle inputs synchronous to pclk; APB slave, no wait
// Notes:   break counters live outside; break flags arrive as pulses
`timescale 1ns/10ps
module etrc_top
  import etrc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Emulated CPU bus cycle
  input  wire logic        cyc_valid,
  input  wire logic [1:0]  cyc_type,
  input  wire logic [15:0] cyc_addr,
  input  wire logic [7:0]  cyc_data,
  input  wire logic        cyc_first_op,
  input  wire logic        cyc_line_start,
  input  wire logic [11:0] probe_in,
  // Break logic
  input  wire logic        first_break_event,
  input  wire logic        second_break_event,
  input  wire logic        break_halt,
  output logic             break_init,
  // Emulated CPU control
  input  wire logic        cpu_next_is_call,
  input  wire logic [15:0] cpu_call_ret_addr,
  input  wire logic        cpu_step_done,
  output logic             cpu_run,
  output logic             cpu_step,
  output logic             cpu_reset,
  output logic             mem_access_en,
  output logic             running
);
  etrc_state_e      state;
  etrc_state_e      next_state;
  logic [31:0]      flt [3];
  logic [11:0]      fcfg;
  logic [10:0]      tmode;
  logic [2:0]       irq_stat;
  logic [2:0]       irq_mask;
  logic [14:0]      rd_idx;
  logic [14:0]      frame_cnt;
  logic [FRAME_W-1:0] rd_frame;
  logic [2:0]       act_en;
  logic             tracing;
  logic [31:0]      tstamp;
  logic [8:0]       tb_cnt;
  logic [8:0]       tb_div;
  logic [7:0]       rst_cnt;
  logic             tbp_on;
  logic [15:0]      tbp_addr;
  logic [2:0]       hit;
  logic             qual_ok;
  logic             trace_we;
  logic             active;
  logic             exec_start;
  logic             exec_end;
  logic             brk_stop;
  logic             wr_acc;
  logic             rd_acc;
  logic [5:0]       cmd;
  logic             full;
  logic             addr_ok;
  logic [31:0]      rd_mux;
  etrc_tmode_e      tm;

  assign tm = etrc_tmode_e'(tmode[2:0]);

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign cmd    = wr_acc && paddr == A_CTRL ? pwdata[5:0] : 6'h00;
  assign pready = 1'b1;

  // Map check
  always_comb begin
    addr_ok = paddr[1:0] == 2'h0 && paddr <= A_TCNT;
  end

  // Error on unmapped word
  assign pslverr = psel & penable & ~addr_ok;

  // Write-side configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmode  <= TMODE_RST;
      fcfg   <= FCFG_RST;
      flt[0] <= FLT_RST;
      flt[1] <= FLT_RST;
      flt[2] <= FLT_RST;
      irq_mask <= 3'h0;
      rd_idx <= 15'h0000;
    end else if (wr_acc) begin
      unique case (paddr)
        A_TMODE: tmode  <= pwdata[10:0];
        A_FLT0:  flt[0] <= pwdata;
        A_FLT1:  flt[1] <= pwdata;
        A_FLT2:  flt[2] <= pwdata;
        A_FCFG:  fcfg   <= pwdata[11:0];
        A_IRQM:  irq_mask <= pwdata[2:0];
        A_TADDR: rd_idx <= pwdata[14:0];
        default: ;
      endcase
    end
  end

  // Read mux
  always_comb begin
    unique case (paddr)
      A_TMODE: rd_mux = {21'h0, tmode};
      A_FLT0:  rd_mux = flt[0];
      A_FLT1:  rd_mux = flt[1];
      A_FLT2:  rd_mux = flt[2];
      A_FCFG:  rd_mux = {17'h0, act_en, fcfg};
      A_STAT:  rd_mux = {26'h0, tbp_on, full, tracing, running,
                         state};
      A_IRQS:  rd_mux = {29'h0, irq_stat};
      A_IRQM:  rd_mux = {29'h0, irq_mask};
      A_TADDR: rd_mux = {17'h0, rd_idx};
      A_TDAT0: rd_mux = rd_frame[31:0];
      A_TDAT1: rd_mux = rd_frame[63:32];
      A_TDAT2: rd_mux = {24'h0, rd_frame[71:64]};
      A_TCNT:  rd_mux = {17'h0, frame_cnt};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Run control state machine
  assign brk_stop = break_halt
                  | (tbp_on && cyc_valid && cyc_type == CY_FETCH
                     && cyc_first_op && cyc_addr == tbp_addr);

  always_comb begin
    next_state = state;
    unique case (state)
      RC_HALT: begin
        if (cmd[C_RUN] && rst_cnt == 8'h00) begin
          next_state = RC_INIT;
        end else if (cmd[C_OVER] && cpu_next_is_call
                     && rst_cnt == 8'h00) begin
          next_state = RC_INIT;
        end else if ((cmd[C_STEP] || cmd[C_OVER])
                     && rst_cnt == 8'h00) begin
          next_state = RC_STEP;
        end
      end
      RC_INIT: next_state = RC_RUN;
      RC_RUN: begin
        if (cmd[C_STOP] || brk_stop) begin
          next_state = RC_HALT;
        end
      end
      RC_STEP: begin
        if (cpu_step_done || cmd[C_STOP]) begin
          next_state = RC_HALT;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RC_HALT;
    end else begin
      state <= next_state;
    end
  end

  // Temporary breakpoint for step-over of a call
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbp_on   <= 1'b0;
      tbp_addr <= 16'h0000;
    end else if (state == RC_HALT && cmd[C_OVER]
                 && cpu_next_is_call) begin
      tbp_on   <= 1'b1;
      tbp_addr <= cpu_call_ret_addr;
    end else if (state == RC_RUN && next_state == RC_HALT) begin
      tbp_on   <= 1'b0;
    end
  end

  // CPU control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_init <= 1'b0;
      cpu_step   <= 1'b0;
    end else begin
      break_init <= next_state == RC_INIT;
      cpu_step   <= state == RC_HALT && next_state == RC_STEP;
    end
  end

  assign cpu_run       = state == RC_RUN;
  assign running       = state == RC_RUN;
  assign mem_access_en = state == RC_HALT;

  // Hardware reset pulse to the emulated CPU
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt <= 8'h00;
    end else if (cmd[C_CRST]) begin
      rst_cnt <= RST_CYC;
    end else if (rst_cnt != 8'h00) begin
      rst_cnt <= rst_cnt - 8'h01;
    end
  end

  assign cpu_reset = rst_cnt != 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Trace start and stop
  assign active     = state == RC_RUN || state == RC_STEP;
  assign exec_start = state != RC_RUN && state != RC_STEP
                      && (next_state == RC_RUN
                          || next_state == RC_STEP);
  assign exec_end   = active && next_state == RC_HALT;
  assign full       = frame_cnt == MAX_FRAMES;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tracing <= 1'b0;
    end else if (exec_start) begin
      tracing <= tm == TM_RUN_RUN || tm == TM_RUN_EVT
                 || tm == TM_RUN_SW;
    end else if (active) begin
      if (second_break_event
          && (tm == TM_RUN_EVT || tm == TM_EVT_EVT)) begin
        tracing <= 1'b0;
      end else if (first_break_event
                   && (tm == TM_EVT_RUN || tm == TM_EVT_EVT)) begin
        tracing <= 1'b1;
      end
      if (exec_end && (tm == TM_RUN_RUN || tm == TM_EVT_RUN
                       || tm == TM_RUN_SW)) begin
        tracing <= 1'b0;
      end
    end
  end

  // Active filter set, switched on the first break event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_en <= 3'h7;
    end else if (exec_start) begin
      act_en <= fcfg[8:6];
    end else if (active && first_break_event
                 && tm == TM_RUN_SW) begin
      act_en <= fcfg[11:9];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Filter match per filter
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      hit[k] = act_en[k] && cyc_type == fcfg[2*k +: 2]
               && cyc_addr >= flt[k][15:0]
               && cyc_addr <= flt[k][31:16];
    end
  end

  // Program fetch qualification
  always_comb begin
    if (cyc_type != CY_FETCH) begin
      qual_ok = 1'b1;
    end else if (tmode[4:3] == Q_OPC) begin
      qual_ok = cyc_first_op;
    end else if (tmode[4:3] == Q_LINE) begin
      qual_ok = cyc_first_op & cyc_line_start;
    end else begin
      qual_ok = 1'b1;
    end
  end

  assign trace_we = cyc_valid && tracing && active && qual_ok
                    && |hit && !full;

  // Frame counter; oldest frame at index zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt <= 15'h0000;
    end else if (cmd[C_CLR]) begin
      frame_cnt <= 15'h0000;
    end else if (trace_we) begin
      frame_cnt <= frame_cnt + 15'h0001;
    end
  end

  // Time stamp divider and counter
  always_comb begin
    unique case (tmode[6:5])
      2'h1:    tb_div = TB1_CYC;
      2'h2:    tb_div = TB2_CYC;
      default: tb_div = TB0_CYC;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_cnt <= 9'h000;
      tstamp <= 32'h0000_0000;
    end else if (cmd[C_CLR] && !active) begin
      tb_cnt <= 9'h000;
      tstamp <= 32'h0000_0000;
    end else if (active) begin
      if (tb_cnt >= tb_div - 9'h001) begin
        tb_cnt <= 9'h000;
        tstamp <= tstamp + 32'h0000_0001;
      end else begin
        tb_cnt <= tb_cnt + 9'h001;
      end
    end
  end

  // Trace memory
  etrc_mem u_mem (
    .pclk  (pclk),
    .we    (trace_we),
    .waddr (frame_cnt),
    .wdata ({second_break_event, first_break_event, cyc_type,
             tstamp, probe_in, cyc_data, cyc_addr}),
    .raddr (rd_idx),
    .rdata (rd_frame)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sticky status; a read clears only the bits it returned; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= (irq_stat & ~(rd_acc && paddr == A_IRQS
                                ? prdata[2:0] : 3'h0))
                  | {state == RC_STEP && next_state == RC_HALT,
                     trace_we && frame_cnt == MAX_FRAMES - 15'h0001,
                     state == RC_RUN && brk_stop};
    end
  end

  assign irq = |(irq_stat & irq_mask);
endmodule

// ==== src/etrc_pkg.sv ====
// Purpose: constants for the emulator trace and run-control block
// Assumes: 50 MHz pclk, APB register access
// Notes:   offsets are byte addresses of aligned 32-bit words
package etrc_pkg;
  // Trace frame and memory geometry
  localparam int FRAME_W  = 72;
  localparam int MEM_AW   = 15;
  localparam logic [14:0] MAX_FRAMES = 15'h7FFE;

  // Clock and time-stamp bases
  localparam int CLK_NS    = 20;
  localparam int TB0_NS    = 100;
  localparam int TB1_NS    = 1000;
  localparam int TB2_NS    = 10000;
  localparam logic [8:0] TB0_CYC = 9'(TB0_NS / CLK_NS);
  localparam logic [8:0] TB1_CYC = 9'(TB1_NS / CLK_NS);
  localparam logic [8:0] TB2_CYC = 9'(TB2_NS / CLK_NS);
  localparam int RST_NS    = 1000;
  localparam logic [7:0] RST_CYC = 8'(RST_NS / CLK_NS);

  // Register offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_TMODE = 8'h04;
  localparam logic [7:0] A_FLT0  = 8'h08;
  localparam logic [7:0] A_FLT1  = 8'h0C;
  localparam logic [7:0] A_FLT2  = 8'h10;
  localparam logic [7:0] A_FCFG  = 8'h14;
  localparam logic [7:0] A_STAT  = 8'h18;
  localparam logic [7:0] A_IRQS  = 8'h1C;
  localparam logic [7:0] A_IRQM  = 8'h20;
  localparam logic [7:0] A_TADDR = 8'h24;
  localparam logic [7:0] A_TDAT0 = 8'h28;
  localparam logic [7:0] A_TDAT1 = 8'h2C;
  localparam logic [7:0] A_TDAT2 = 8'h30;
  localparam logic [7:0] A_TCNT  = 8'h34;

  // CTRL command bit positions (write one to act)
  localparam int C_RUN  = 0;
  localparam int C_STOP = 1;
  localparam int C_STEP = 2;
  localparam int C_OVER = 3;
  localparam int C_CRST = 4;
  localparam int C_CLR  = 5;

  // IRQ status bit positions
  localparam int I_BRK  = 0;
  localparam int I_FULL = 1;
  localparam int I_STEP = 2;

  // Reset values
  localparam logic [31:0] FLT_RST  = 32'hFFFF_0000;
  localparam logic [11:0] FCFG_RST = 12'h1E4;
  localparam logic [10:0] TMODE_RST = 11'h000;

  // Cycle types
  localparam logic [1:0] CY_FETCH = 2'h0;
  localparam logic [1:0] CY_XWR   = 2'h1;
  localparam logic [1:0] CY_XRD   = 2'h2;

  // Program filter qualification
  localparam logic [1:0] Q_OPC  = 2'h0;
  localparam logic [1:0] Q_LINE = 2'h1;

  // Trace start/stop modes
  typedef enum logic [2:0] {
    TM_RUN_RUN = 3'b000,
    TM_RUN_EVT = 3'b001,
    TM_EVT_RUN = 3'b010,
    TM_EVT_EVT = 3'b011,
    TM_RUN_SW  = 3'b100
  } etrc_tmode_e;

  // Run-control states
  typedef enum logic [1:0] {
    RC_HALT = 2'b00,
    RC_INIT = 2'b01,
    RC_RUN  = 2'b10,
    RC_STEP = 2'b11
  } etrc_state_e;
endpackage

// ==== src/etrc_mem.sv ====
// Purpose: trace frame memory, one write port, one read port
// Assumes: single clock; read data registered
// Notes:   reads never disturb writes, so on-the-fly access is safe
`timescale 1ns/10ps
module etrc_mem #(
  parameter int W  = etrc_pkg::FRAME_W,
  parameter int AW = etrc_pkg::MEM_AW
) (
  // Clock
  input  wire logic          pclk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] store [2**AW];

  ////////////////////////////////////////////////////////////////////////
  // Write side
  always_ff @(posedge pclk) begin
    if (we) begin
      store[waddr] <= wdata;
    end
  end

  // Registered read side
  always_ff @(posedge pclk) begin
    rdata <= store[raddr];
  end
endmodule

// ==== dv/etrc_sva.sv ====
// Purpose: run-control assertions for the trace block
// Assumes: one pclk domain, presetn async active low
// Notes:   sees only top-level ports
`timescale 1ns/10ps
module etrc_sva
  import etrc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  // Run control
  input wire logic break_halt,
  input wire logic break_init,
  input wire logic cpu_run,
  input wire logic cpu_step,
  input wire logic cpu_reset,
  input wire logic mem_access_en,
  input wire logic running
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // Length of the current CPU reset pulse
  logic [7:0] rcnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rcnt <= 8'h00;
    else
      rcnt <= cpu_reset ? rcnt + 8'h01 : 8'h00;
  end
  // Held, then released one cycle later
  sequence s_init;
    !cpu_run ##1 cpu_run;
  endsequence
  sequence s_rd_run;
    psel && penable && !pwrite && running && !break_halt;
  endsequence
  ////////////////////////////////////////
  a_init_run: assert property (break_init |-> s_init)
    else $error("cpu not released after init");
  a_led_run: assert property ($rose(cpu_run)
    |-> $past(break_init) && running)
    else $error("run started without init or indicator");
  a_no_wait: assert property (psel && penable |-> pready)
    else $error("apb access stalled");
  a_rd_keeps: assert property (s_rd_run |=> running)
    else $error("read disturbed the run");
  a_brk_halt: assert property (cpu_run && break_halt |=> !cpu_run)
    else $error("break did not halt");
  a_mem_halt: assert property ($fell(running) |-> mem_access_en)
    else $error("no memory access after halt");
  a_mem_run: assert property (running |-> !mem_access_en)
    else $error("memory access while running");
  a_rst_len: assert property ($fell(cpu_reset) && $past(presetn)
    |-> rcnt == RST_CYC)
    else $error("cpu reset pulse length wrong");
  a_rst_norun: assert property (cpu_reset |-> !cpu_run)
    else $error("cpu runs in reset");
  a_step_one: assert property (cpu_step |-> !cpu_run ##1 !cpu_step)
    else $error("step pulse malformed");
endmodule
bind etrc_top etrc_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .break_halt(break_halt),
  .break_init(break_init), .cpu_run(cpu_run), .cpu_step(cpu_step),
  .cpu_reset(cpu_reset), .mem_access_en(mem_access_en),
  .running(running)
);

// ==== dv/etrc_cpu_model.sv ====
// Purpose: emulated CPU bus model
// Assumes: rnd changes every cycle
// Notes:   idle field lines carry noise, never stale values
`timescale 1ns/10ps
module etrc_cpu_model (
  // Clock, reset, noise source
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] rnd,
  // Control from the block
  input  wire logic        cpu_run,
  input  wire logic        cpu_step,
  input  wire logic        cpu_reset,
  // Bus cycles and step completion
  output logic             cyc_valid,
  output logic [1:0]       cyc_type,
  output logic [15:0]      cyc_addr,
  output logic [7:0]       cyc_data,
  output logic             cyc_first_op,
  output logic             cyc_line_start,
  output logic [11:0]      probe_in,
  output logic             cpu_step_done
);
  logic step_d;
  // Fields follow the noise every cycle
  always_comb begin
    cyc_type = (rnd[14:13] == 2'h3) ? 2'h0 : rnd[14:13];
    cyc_addr = {6'h00, rnd[24:15]};
    cyc_data = rnd[31:24];
    cyc_first_op = rnd[1];
    cyc_line_start = rnd[2];
    probe_in = rnd[27:16];
  end
  // Cycles at random pace while released, one per step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_valid <= 1'b0;
      step_d <= 1'b0;
      cpu_step_done <= 1'b0;
    end else begin
      step_d <= cpu_step;
      cpu_step_done <= step_d;
      // No bus cycles while held in reset
      cyc_valid <= !cpu_reset && (cpu_step || (cpu_run && rnd[0]));
    end
  end
endmodule

// ==== dv/etrc_bench.sv ====
// Purpose: self-checking bench for trace and run control
// Assumes: 50 MHz pclk, reset held three cycles
// Notes:   frames predicted by a queue model fed from the ports
`timescale 1ns/10ps
module etrc_bench;
  import etrc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, rnd = 32'h02F7B1D5;
  logic pready, pslverr, irq, er, cyc_valid, cyc_first_op;
  logic cyc_line_start, break_init, cpu_step_done, cpu_run, cpu_step;
  logic cpu_reset, mem_access_en, running, run_q = 1'b0, stp = 1'b0;
  logic [1:0] cyc_type;
  logic [15:0] cyc_addr;
  logic [7:0] cyc_data;
  logic [11:0] probe_in;
  logic fev = 1'b0, sev = 1'b0, brk = 1'b0, call = 1'b0;
  int error_cnt = 0, checks_done = 0, mode = 0, qual = 0, trc = 0;
  int msk = 7, mst = 7, msw = 0;
  int flo[3] = '{0, 0, 0}, fhi[3] = '{65535, 65535, 65535};
  int fty[3] = '{0, 1, 2};
  logic [39:0] q[$];
  always #10 pclk = ~pclk;
  ////////////////////////////////////////
  etrc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .cyc_valid(cyc_valid), .cyc_type(cyc_type), .cyc_addr(cyc_addr),
    .cyc_data(cyc_data), .cyc_first_op(cyc_first_op),
    .cyc_line_start(cyc_line_start), .probe_in(probe_in),
    .first_break_event(fev), .second_break_event(sev),
    .break_halt(brk), .break_init(break_init), .cpu_next_is_call(call),
    .cpu_call_ret_addr(16'h0150), .cpu_step_done(cpu_step_done),
    .cpu_run(cpu_run), .cpu_step(cpu_step), .cpu_reset(cpu_reset),
    .mem_access_en(mem_access_en), .running(running));
  etrc_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .rnd(rnd),
    .cpu_run(cpu_run), .cpu_step(cpu_step), .cpu_reset(cpu_reset),
    .cyc_valid(cyc_valid), .cyc_type(cyc_type), .cyc_addr(cyc_addr),
    .cyc_data(cyc_data), .cyc_first_op(cyc_first_op),
    .cyc_line_start(cyc_line_start), .probe_in(probe_in),
    .cpu_step_done(cpu_step_done));
  ////////////////////////////////////////
  // Noise source for the bus model
  function automatic logic [31:0] xs(logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  always @(posedge pclk) rnd <= xs(rnd);
  // Cycle passes the active filters and fetch qualification
  function automatic int hit(logic [1:0] t, logic [15:0] a, logic fo,
                             logic ls);
    int h;
    h = 0;
    for (int k = 0; k < 3; k++)
      if (msk[k] && fty[k] == t && a >= flo[k] && a <= fhi[k]) h = 1;
    if (t == CY_FETCH && ((qual == 0 && !fo)
                          || (qual == 1 && !(fo && ls)))) h = 0;
    return h;
  endfunction
  // Reference model: capture first, then this edge's events
  always @(posedge pclk) begin
    if (cyc_valid === 1'b1 && trc != 0 && (running === 1'b1 || stp) &&
        q.size() < 32766 &&
        hit(cyc_type, cyc_addr, cyc_first_op, cyc_line_start) != 0)
      q.push_back({sev, fev, cyc_type, probe_in, cyc_data,
                   cyc_addr});
    if (break_init === 1'b1 || cpu_step === 1'b1) begin
      msk = mst;
      trc = (mode == 2 || mode == 3) ? 0 : 1;
    end
    if (cpu_step === 1'b1) stp = 1'b1;
    if (cpu_step_done === 1'b1) stp = 1'b0;
    if (fev && (mode == 2 || mode == 3)) trc = 1;
    if (fev && mode == 4) msk = msw;
    if (sev && (mode == 1 || mode == 3)) trc = 0;
    if ((run_q && !running) || cpu_step_done) trc = 0;
    run_q = running;
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [35:0] s,
                     input logic [35:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; writes also update the model
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a == A_TMODE) mode = d[2:0];
    if (w && a == A_TMODE) qual = d[4:3];
    if (w && a >= A_FLT0 && a <= A_FLT2) flo[a / 4 - 2] = d[15:0];
    if (w && a >= A_FLT0 && a <= A_FLT2) fhi[a / 4 - 2] = d[31:16];
    if (w && a == A_FCFG) fty = '{d[1:0], d[3:2], d[5:4]};
    if (w && a == A_FCFG) mst = d[8:6];
    if (w && a == A_FCFG) msw = d[11:9];
    if (w && a == A_CTRL && d[5]) q.delete();
  endtask
  // One-cycle pulse: 0 first event, 1 second event, 2 break halt
  task automatic pulse(input int w);
    @(posedge pclk);
    if (w == 0) fev <= 1'b1;
    else if (w == 1) sev <= 1'b1;
    else brk <= 1'b1;
    @(posedge pclk);
    fev <= 1'b0;
    sev <= 1'b0;
    brk <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    wrap_up();
  end
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_FLT2, 32'h0);
    chk("filter reset", rd, FLT_RST);
    apb(1'b0, A_FCFG, 32'h0);
    chk("fcfg reset", rd[11:0], FCFG_RST);
    apb(1'b0, 8'h38, 32'h0);
    chk("unmapped", {er, rd}, 36'h100000000);
    apb(1'b1, A_FLT0, 32'h01FF0100);
    apb(1'b1, A_FLT1, 32'h00FF0000);
    apb(1'b1, A_FCFG, 32'h00000464);
    // CPU reset refuses a run
    apb(1'b1, A_CTRL, 32'h10);
    apb(1'b1, A_CTRL, 32'h01);
    repeat (3) @(posedge pclk);
    chk("run in reset", {cpu_reset, running}, 2'b10);
    for (int i = 0; i < 60 && cpu_reset !== 1'b0; i++) @(posedge pclk);
    // Every trace mode and qualification, stop by host or break
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, A_TMODE, {27'h0, 2'(m % 3), 3'(m)});
      apb(1'b1, A_IRQM, {31'h0, m < 3});
      apb(1'b1, A_CTRL, 32'h20);
      apb(1'b1, A_CTRL, 32'h01);
      repeat (40) @(posedge pclk);
      pulse(0);
      repeat (40) @(posedge pclk);
      apb(1'b0, A_TCNT, 32'h0);
      chk("run during read", running, 1'b1);
      pulse(1);
      repeat (40) @(posedge pclk);
      if (m % 2 == 1) apb(1'b1, A_CTRL, 32'h02);
      else pulse(2);
      repeat (2) @(posedge pclk);
      chk("halt", {running, mem_access_en}, 2'b01);
      chk("irq", irq, m % 2 == 0 && m < 3);
      apb(1'b0, A_IRQS, 32'h0);
      chk("break status", rd, m % 2 == 0);
      @(posedge pclk);
      chk("irq cleared", irq, 1'b0);
      apb(1'b0, A_TCNT, 32'h0);
      chk("frame count", rd, q.size());
      for (int i = 0; i < q.size(); i++) begin
        apb(1'b1, A_TADDR, i);
        apb(1'b0, A_TDAT0, 32'h0);
        chk("frame", rd, q[i][31:0]);
        apb(1'b0, A_TDAT2, 32'h0);
        chk("frame top", rd, {q[i][39:36], 4'h0});
      end
    end
    // Step over a call runs; without a call it single-steps
    call <= 1'b1;
    apb(1'b1, A_CTRL, 32'h08);
    repeat (4) @(posedge pclk);
    chk("over call", running, 1'b1);
    apb(1'b1, A_CTRL, 32'h02);
    call <= 1'b0;
    apb(1'b1, A_CTRL, 32'h20);
    apb(1'b1, A_TMODE, 32'h10);
    apb(1'b1, A_CTRL, 32'h08);
    for (int i = 0; i < 20 && cpu_step_done !== 1'b1; i++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    chk("step halted", running, 1'b0);
    apb(1'b0, A_IRQS, 32'h0);
    chk("step status", rd, 32'h4);
    apb(1'b0, A_TCNT, 32'h0);
    chk("step frames", rd, q.size());
    wrap_up();
  end
endmodule
